//--- hdl/sie_edge_irq.sv
// ============================================================
// Edge select registers and comparator edge detection for 24 inputs
// Assumes register requests arrive synchronous to ref_clk from the serial port logic
// Functional notes
// - Field value zero: no interrupt for the channel whatever the comparator does.
// - Field value one: interrupt only on rising crossing of group threshold.
// - Field value two: interrupt only on falling crossing of group threshold.
// - Field value three: interrupt on both rising and falling crossings.
// - Channels 0-3, 4-7, 8-11 use their own group thresholds.
// - Low register: channel 11 in bits 23-22 down to channel 0 in 1-0.
// - High register at 23h, reset zero, channels 23 down to 12.
// - After reset every edge select field reads zero.
// - Low register sits at 22h and resets to zero.
// - Channels 12-15, 16-19, 20-23 use their own group thresholds.
// - Threshold codes zero to three pick 2V, 2.7V, 3V, 4V levels.
`timescale 1ns/10ps
`include "sie_regs.svh"

module sie_edge_irq
    import sie_pkg::*;
#(
    parameter int CHANNELS = `SIE_CHANNELS
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register access
    input wire sie_reg_req_t reg_req,
    output logic [`SIE_REG_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // Comparator levels and group thresholds
    input wire logic [CHANNELS-1:0][`SIE_LEVELS-1:0] comp_above,
    input wire logic [2*`SIE_GROUPS-1:0] group_threshold_sel,
    // Edge events
    output logic [CHANNELS-1:0] edge_flag,
    output logic edge_any
);

    // ============================================================
    // Registers and samples
    logic [`SIE_REG_W-1:0] channel_edge_irq_select_low;
    logic [`SIE_REG_W-1:0] channel_edge_irq_select_high;
    logic [`SIE_REG_W-1:0] next_select_low;
    logic [`SIE_REG_W-1:0] next_select_high;
    logic [`SIE_REG_W-1:0] next_rdata;
    logic next_rvalid;
    logic [CHANNELS-1:0] smp;
    logic [CHANNELS-1:0] cur_cmp;
    logic [CHANNELS-1:0] hit;
    logic primed;
    logic [2*CHANNELS-1:0] all_sel;

    assign all_sel = {channel_edge_irq_select_high, channel_edge_irq_select_low};

    // ============================================================
    // Register file
    always_comb begin
        next_select_low = channel_edge_irq_select_low;
        next_select_high = channel_edge_irq_select_high;
        next_rdata = reg_rdata;
        next_rvalid = reg_req.rd;
        if (reg_req.wr && reg_req.addr == `SIE_OFS_SEL_LOW) begin
            next_select_low = reg_req.wdata;
        end else if (reg_req.wr && reg_req.addr == `SIE_OFS_SEL_HIGH) begin
            next_select_high = reg_req.wdata;
        end
        if (reg_req.rd) begin
            if (reg_req.addr == `SIE_OFS_SEL_LOW) begin
                next_rdata = channel_edge_irq_select_low;
            end else if (reg_req.addr == `SIE_OFS_SEL_HIGH) begin
                next_rdata = channel_edge_irq_select_high;
            end else begin
                next_rdata = `SIE_RDATA_RESET;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            channel_edge_irq_select_low <= `SIE_SEL_RESET;
            channel_edge_irq_select_high <= `SIE_SEL_RESET;
            reg_rdata <= `SIE_RDATA_RESET;
            reg_rvalid <= 1'b0;
        end else begin
            channel_edge_irq_select_low <= next_select_low;
            channel_edge_irq_select_high <= next_select_high;
            reg_rdata <= next_rdata;
            reg_rvalid <= next_rvalid;
        end
    end

    // ============================================================
    // Threshold pick and per-channel edge decision
    for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
        localparam int G = i / `SIE_GROUP_SIZE;
        assign cur_cmp[i] = comp_above[i][group_threshold_sel[2*G +: 2]];
        sie_chan_edge sie_chan_edge_i (
            .edge_sel(all_sel[2*i +: 2]),
            .now_above(cur_cmp[i]),
            .was_above(smp[i]),
            .primed(primed),
            .hit(hit[i])
        );
    end

    // ============================================================
    // Sample and event registers
    logic [CHANNELS-1:0] next_smp;
    logic [CHANNELS-1:0] next_flag;
    logic next_any;
    logic next_primed;

    always_comb begin
        next_smp = cur_cmp;
        next_flag = hit;
        next_any = |hit;
        next_primed = 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            smp <= '0;
            edge_flag <= '0;
            edge_any <= 1'b0;
            primed <= 1'b0;
        end else begin
            smp <= next_smp;
            edge_flag <= next_flag;
            edge_any <= next_any;
            primed <= next_primed;
        end
    end

    // ============================================================
    // Checks
    logic [CHANNELS-1:0] m_none;
    logic [CHANNELS-1:0] m_rise;
    logic [CHANNELS-1:0] m_fall;
    logic [CHANNELS-1:0] m_both;
    logic [CHANNELS-1:0] up;
    logic [CHANNELS-1:0] dn;

    always_comb begin
        for (int k = 0; k < CHANNELS; k++) begin
            m_none[k] = all_sel[2*k +: 2] == 2'h0;
            m_rise[k] = all_sel[2*k +: 2] == 2'h1;
            m_fall[k] = all_sel[2*k +: 2] == 2'h2;
            m_both[k] = all_sel[2*k +: 2] == 2'h3;
        end
        up = cur_cmp & ~smp & {CHANNELS{primed}};
        dn = ~cur_cmp & smp & {CHANNELS{primed}};
    end

    property p_none_quiet;
        @(posedge ref_clk) disable iff (sys_rst)
        1 |=> (edge_flag & $past(m_none)) == '0;
    endproperty
    a_none_quiet: assert property (p_none_quiet) else $error("Flag on disabled channel");

    property p_rise_only;
        @(posedge ref_clk) disable iff (sys_rst)
        1 |=> (edge_flag & $past(m_rise)) == ($past(up) & $past(m_rise));
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("Rising mode flag mismatch");

    property p_fall_only;
        @(posedge ref_clk) disable iff (sys_rst)
        1 |=> (edge_flag & $past(m_fall)) == ($past(dn) & $past(m_fall));
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("Falling mode flag mismatch");

    property p_both_edges;
        @(posedge ref_clk) disable iff (sys_rst)
        1 |=> (edge_flag & $past(m_both)) == ($past(up | dn) & $past(m_both));
    endproperty
    a_both_edges: assert property (p_both_edges) else $error("Both edge flag mismatch");

    property p_low_groups;
        @(posedge ref_clk) disable iff (sys_rst)
        cur_cmp[9] == comp_above[9][group_threshold_sel[5:4]] && cur_cmp[6] == comp_above[6][group_threshold_sel[3:2]];
    endproperty
    a_low_groups: assert property (p_low_groups) else $error("Low group threshold wrong");

    property p_low_write;
        @(posedge ref_clk) disable iff (sys_rst)
        reg_req.wr && reg_req.addr == `SIE_OFS_SEL_LOW |=> all_sel[23:0] == $past(reg_req.wdata);
    endproperty
    a_low_write: assert property (p_low_write) else $error("Low register write lost");

    property p_high_write;
        @(posedge ref_clk) disable iff (sys_rst)
        reg_req.wr && reg_req.addr == `SIE_OFS_SEL_HIGH |=> all_sel[47:24] == $past(reg_req.wdata);
    endproperty
    a_high_write: assert property (p_high_write) else $error("High register write lost");

    property p_reset_zero;
        @(posedge ref_clk)
        sys_rst |=> all_sel == '0 && edge_flag == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("Fields not zero after reset");

    property p_low_read;
        @(posedge ref_clk) disable iff (sys_rst)
        reg_req.rd && reg_req.addr == `SIE_OFS_SEL_LOW |=> reg_rvalid && reg_rdata == $past(channel_edge_irq_select_low);
    endproperty
    a_low_read: assert property (p_low_read) else $error("Low register read wrong");

    property p_high_groups;
        @(posedge ref_clk) disable iff (sys_rst)
        cur_cmp[21] == comp_above[21][group_threshold_sel[11:10]] && cur_cmp[13] == comp_above[13][group_threshold_sel[7:6]];
    endproperty
    a_high_groups: assert property (p_high_groups) else $error("High group threshold wrong");

    property p_flag_needs_change;
        @(posedge ref_clk) disable iff (sys_rst)
        edge_any |-> ($past(cur_cmp) != $past(smp)) && edge_flag != '0;
    endproperty
    a_flag_needs_change: assert property (p_flag_needs_change) else $error("Flag without comparator change");

endmodule : sie_edge_irq

//--- hdl/sie_regs.svh
// ============================================================
// Register offsets, field layout and reset values for the edge select block
// Assumes inclusion by bare name from the package and the design modules
`ifndef SIE_REGS_SVH
`define SIE_REGS_SVH

// ============================================================
// Geometry
`define SIE_CHANNELS 24
`define SIE_FIELD_W 2
`define SIE_GROUP_SIZE 4
`define SIE_GROUPS 6
`define SIE_LEVELS 4
`define SIE_REG_W 24
`define SIE_ADDR_W 6

// ============================================================
// Register offsets
`define SIE_OFS_SEL_LOW 6'h22
`define SIE_OFS_SEL_HIGH 6'h23

// ============================================================
// Reset values
`define SIE_SEL_RESET 24'h000000
`define SIE_RDATA_RESET 24'h000000

`endif

//--- hdl/sie_pkg.sv
// ============================================================
// Types shared by the edge select block
// Assumes sie_regs.svh is on the include path
`include "sie_regs.svh"

package sie_pkg;

    // Edge selection per channel field
    typedef enum logic [1:0] {
        SIE_EDGE_NONE,
        SIE_EDGE_RISE,
        SIE_EDGE_FALL,
        SIE_EDGE_BOTH
    } sie_edge_mode_t;

    // Comparator threshold codes: 2V, 2.7V, 3V, 4V
    typedef enum logic [1:0] {
        SIE_THR_2V0,
        SIE_THR_2V7,
        SIE_THR_3V0,
        SIE_THR_4V0
    } sie_thr_code_t;

    // Register access request from the serial interface logic
    typedef struct packed {
        logic wr;
        logic rd;
        logic [`SIE_ADDR_W-1:0] addr;
        logic [`SIE_REG_W-1:0] wdata;
    } sie_reg_req_t;

endpackage : sie_pkg

//--- hdl/sie_chan_edge.sv
// ============================================================
// Per-channel edge decision from the current and previous comparator sample
// Assumes the caller registers the sample and the result
`timescale 1ns/10ps

module sie_chan_edge
    import sie_pkg::*;
(
    // Selection and samples
    input wire logic [1:0] edge_sel,
    input wire logic now_above,
    input wire logic was_above,
    input wire logic primed,
    // Result
    output logic hit
);

    sie_edge_mode_t mode;
    logic rise;
    logic fall;

    // ============================================================
    // Edge decode
    always_comb begin
        mode = sie_edge_mode_t'(edge_sel);
        rise = primed & now_above & ~was_above;
        fall = primed & ~now_above & was_above;
        case (mode)
            SIE_EDGE_NONE: hit = 1'b0;
            SIE_EDGE_RISE: hit = rise;
            SIE_EDGE_FALL: hit = fall;
            SIE_EDGE_BOTH: hit = rise | fall;
            default: hit = 1'b0;
        endcase
    end

endmodule : sie_chan_edge

//--- testbench/sie_host_model.sv
// Host side model issuing register reads and writes
// Assumes the edge select block answers reads one cycle after the strobe
`timescale 1ns/10ps
`include "sie_regs.svh"

module sie_host_model
    import sie_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Register access
    output sie_reg_req_t reg_req,
    input wire logic [`SIE_REG_W-1:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial reg_req = '0;

    task automatic write_reg(input logic [5:0] addr, input logic [23:0] data);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask : write_reg

    task automatic read_reg(input logic [5:0] addr, output logic [23:0] data, output logic valid);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: ~reg_req.wdata};
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~reg_req.wdata};
        @(posedge ref_clk);
        data = reg_rdata;
        valid = reg_rvalid;
    endtask : read_reg
endmodule : sie_host_model

//--- testbench/switch_input_edge_irq_enable_test.sv
// Self-checking bench for the edge select block
// Assumes the host model drives the register port
`timescale 1ns/10ps
`include "sie_regs.svh"

module switch_input_edge_irq_enable_test;
    import sie_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    sie_reg_req_t reg_req;
    logic [23:0] reg_rdata;
    logic reg_rvalid;
    logic [23:0][3:0] comp_above = '0;
    logic [11:0] group_threshold_sel = 12'h9e4;
    logic [23:0] edge_flag;
    logic edge_any;
    int fail_count = 0;
    int samples_checked = 0;
    int cycle_count = 0;

    sie_edge_irq sie_edge_irq_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .comp_above(comp_above),
        .group_threshold_sel(group_threshold_sel), .edge_flag(edge_flag), .edge_any(edge_any));
    sie_host_model sie_host_model_i (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    initial forever #50 ref_clk = ~ref_clk;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    always @(posedge ref_clk) begin
        cycle_count++;
        if (cycle_count == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic read_expect(input logic [5:0] addr, input logic [23:0] exp);
        logic [23:0] d;
        logic v;
        sie_host_model_i.read_reg(addr, d, v);
        check("reg_rvalid", 24'h000001, {23'h0, v});
        check("reg_rdata", exp, d);
    endtask : read_expect

    task automatic edge_step(input int ch, input int lvl, input logic val, input logic exp);
        logic [23:0] want;
        want = '0;
        want[ch] = exp;
        @(posedge ref_clk);
        comp_above[ch][lvl] <= val;
        repeat (2) @(posedge ref_clk);
        check("edge_flag", want, edge_flag);
        check("edge_any", {23'h0, exp}, {23'h0, edge_any});
        @(posedge ref_clk);
        check("edge_flag_after", 24'h000000, edge_flag);
        check("edge_any_after", 24'h000000, {23'h0, edge_any});
    endtask : edge_step

    task automatic test_reset_values;
        read_expect(6'h22, 24'h000000);
        read_expect(6'h23, 24'h000000);
        read_expect(6'h21, 24'h000000);
    endtask : test_reset_values

    task automatic test_reg_map;
        sie_host_model_i.write_reg(6'h22, 24'h5a3c96);
        sie_host_model_i.write_reg(6'h23, 24'hc3a5f0);
        sie_host_model_i.write_reg(6'h24, 24'hffffff);
        read_expect(6'h22, 24'h5a3c96);
        read_expect(6'h23, 24'hc3a5f0);
        read_expect(6'h24, 24'h000000);
        sie_host_model_i.write_reg(6'h22, 24'h000000);
        sie_host_model_i.write_reg(6'h23, 24'h000000);
    endtask : test_reg_map

    task automatic test_edge_modes;
        int chans[6] = '{0, 5, 11, 12, 18, 23};
        int ch;
        int lvl;
        logic [1:0] md;
        logic [5:0] addr;
        foreach (chans[i]) begin
            ch = chans[i];
            lvl = group_threshold_sel[2*(ch/4) +: 2];
            addr = (ch < 12) ? 6'h22 : 6'h23;
            for (int m = 0; m < 4; m++) begin
                md = m[1:0];
                sie_host_model_i.write_reg(addr, 24'(md) << (2*(ch%12)));
                edge_step(ch, lvl ^ 1, 1'b1, 1'b0);
                edge_step(ch, lvl ^ 1, 1'b0, 1'b0);
                edge_step(ch, lvl, 1'b1, md[0]);
                edge_step(ch, lvl, 1'b0, md[1]);
            end
            sie_host_model_i.write_reg(addr, 24'h000000);
        end
    endtask : test_edge_modes

    task automatic test_mid_reset;
        sie_host_model_i.write_reg(6'h22, 24'hffffff);
        sie_host_model_i.write_reg(6'h23, 24'hffffff);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        read_expect(6'h22, 24'h000000);
        read_expect(6'h23, 24'h000000);
    endtask : test_mid_reset

    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        test_reset_values();
        test_reg_map();
        test_edge_modes();
        test_mid_reset();
        report_and_stop();
    end
endmodule : switch_input_edge_irq_enable_test
